// ### dv/flash_unlock_and_id_readout_bench.sv
/*
  Self-checking bench for the flash unlock sequencer and identification readout.
  Assumes fuq_core_model supplies slots and flash completion.
*/
module flash_unlock_and_id_readout_bench
  import fuq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, resetn = 0, key_wr = 0, other_wr = 0, wr_trigger = 0, slot, flash_done;
  logic        rd_trigger = 0, config_space_select = 0;
  logic [7:0]  key_data = 8'h00;
  logic [1:0]  wr_op = 2'h0, wr_uid_sel = 2'h0;
  logic [13:0] wr_word = 14'h0000;
  logic [15:0] rd_addr = 16'h0000;
  logic [4:0]  done_dly = 5'h05;
  logic        force_nop, core_stall, flash_start, latch_load, op_refused;
  logic [5:0]  memory_data_high;
  logic [7:0]  memory_data_low;
  int          fail_count = 0, checks_done = 0, n_start = 0, n_load = 0, n_stall = 0, n_ns = 0, n_done = 0;

  always #5 clk = ~clk;

  fuq_flash_seq #(.ROW_CYCLES(20)) DUT (.clk(clk), .resetn(resetn), .key_wr(key_wr), .key_data(key_data),
    .other_wr(other_wr), .wr_trigger(wr_trigger), .wr_op(wr_op), .wr_uid_sel(wr_uid_sel), .wr_word(wr_word),
    .slot(slot), .flash_done(flash_done), .rd_trigger(rd_trigger), .config_space_select(config_space_select),
    .rd_addr(rd_addr), .force_nop(force_nop), .core_stall(core_stall), .flash_start(flash_start),
    .latch_load(latch_load), .op_refused(op_refused), .memory_data_high(memory_data_high),
    .memory_data_low(memory_data_low));

  fuq_core_model #(.SLOT_GAP(3)) core (.clk(clk), .resetn(resetn), .core_stall(core_stall),
    .flash_start(flash_start), .done_dly(done_dly), .slot(slot), .flash_done(flash_done));

  always @(posedge clk)
  begin
    n_start += (flash_start === 1'b1);
    n_load  += (latch_load === 1'b1);
    n_stall += (core_stall === 1'b1);
    n_ns    += (force_nop === 1'b1 && slot === 1'b1);
    n_done  += (flash_done === 1'b1);
  end

  task automatic final_report();
    if (fail_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // which 0 watches force_nop, 1 watches core_stall
  task automatic wait_for(input int which, input logic val);
    int n;
    n = 0;
    while (((which == 0) ? force_nop : core_stall) !== val)
    begin
      if (n == 200)
      begin
        fail_count++;
        $display("BAD %0t wait ran out", $time);
        final_report();
      end
      n++;
      @(posedge clk);
      #1;
    end
  endtask

  task automatic key(input logic [7:0] v);
    @(posedge clk);
    key_wr   <= 1'b1;
    key_data <= v;
    @(posedge clk);
    key_wr <= 1'b0;
  endtask

  task automatic trig(input logic [1:0] op);
    @(posedge clk);
    wr_trigger <= 1'b1;
    wr_op      <= op;
    @(posedge clk);
    wr_trigger <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] addr, input logic [13:0] exp);
    @(posedge clk);
    rd_trigger          <= 1'b1;
    config_space_select <= 1'b1;
    rd_addr             <= addr;
    @(posedge clk);
    rd_trigger <= 1'b0;
    @(posedge clk);
    #1;
    chk({2'b00, memory_data_high, memory_data_low}, {2'b00, exp}, "read word");
  endtask

  task automatic run_op(input logic [1:0] op, input logic [4:0] dly, input bit good, input bit brk);
    int s0, l0, t0, ns0, d0;
    bit ok;
    ok  = good && !brk;
    d0  = n_done;
    s0  = n_start;
    l0  = n_load;
    t0  = n_stall;
    ns0 = n_ns;
    @(posedge clk);
    done_dly   <= dly;
    wr_uid_sel <= 2'h2;
    wr_word    <= 14'h1234;
    key(good ? KEY_FIRST : KEY_SECOND);
    if (brk)
    begin
      @(posedge clk);
      other_wr <= 1'b1;
      @(posedge clk);
      other_wr <= 1'b0;
    end
    key(good ? KEY_SECOND : KEY_FIRST);
    trig(op);
    wait_for(0, 1'b1);
    wait_for(0, 1'b0);
    if (ok && op != OP_LOAD_LATCH)
    begin
      wait_for(1, 1'b0);
      chk(16'(n_stall - t0 > 0), 16'h0001, "stall seen");
      chk(16'(n_stall - t0 <= dly), 16'h0001, "stall outlived flash");
      chk(16'(n_done - d0), 16'h0001, "flash done count");
    end
    else
    begin
      chk(16'(n_stall - t0), 16'h0000, "stall seen");
      chk(16'(n_done - d0), 16'h0000, "flash done count");
    end
    chk(16'(n_ns - ns0), 16'h0002, "forced slots");
    chk(16'(n_start - s0), 16'(ok && op != OP_LOAD_LATCH), "start count");
    chk(16'(n_load - l0), 16'(ok && op == OP_LOAD_LATCH), "load count");
    chk(16'(op_refused), 16'(!good || brk), "refused flag");
  endtask

  initial
  begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    rd(CFG_DEV_ADDR, DEV_ID_DEFAULT);
    chk(16'({memory_data_high, memory_data_low} == ID_INVALID), 16'h0000, "invalid id");
    rd(CFG_REV_ADDR, REV_ID_DEFAULT);
    rd(CFG_WORD1_ADDR, CFG_WORD_RESET);
    rd(CFG_WORD2_ADDR, CFG_WORD_RESET);
    rd(16'h8004, 14'h0000);
    rd(CFG_USER_ID_HI, USER_ID_RESET);
    rd(16'h7FFF, 14'h0000);
    run_op(OP_ROW_ERASE, 5'h05, 1, 0);
    run_op(OP_ROW_PROGRAM, 5'h0F, 1, 0);
    run_op(OP_USER_ID_WR, 5'h05, 1, 0);
    rd(16'h8002, 14'h1234);
    run_op(OP_LOAD_LATCH, 5'h05, 1, 0);
    run_op(OP_ROW_ERASE, 5'h05, 1, 1);
    run_op(OP_ROW_ERASE, 5'h05, 0, 0);
    final_report();
  end
endmodule

// ### dv/fuq_core_model.sv
/*
  Behavioural core and flash macro facing the sequencer: slot pulses and done pulse.
  Assumes the sequencer's stall, start and load outputs are registered on clk.
*/
module fuq_core_model
  import fuq_pkg::*;
#(
  parameter int unsigned SLOT_GAP = 3
)
(
  input  wire logic       clk,         // core clock
  input  wire logic       resetn,      // active-low reset
  input  wire logic       core_stall,  // core halted
  input  wire logic       flash_start, // row operation launched
  input  wire logic [4:0] done_dly,    // cycles from start to done
  output logic            slot,        // one instruction slot elapsed
  output logic            flash_done   // flash macro finished
);
  int unsigned gap_cnt;
  int unsigned done_cnt;

  // software keeps interrupts masked around the key writes, so slots never pause there
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      gap_cnt <= 0;
      slot    <= 1'b0;
    end
    else if (core_stall) // a halted core fetches nothing
    begin
      slot <= 1'b0;
    end
    else
    begin
      gap_cnt <= (gap_cnt == SLOT_GAP - 1) ? 0 : gap_cnt + 1;
      slot    <= (gap_cnt == SLOT_GAP - 1);
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      done_cnt   <= 0;
      flash_done <= 1'b0;
    end
    else
    begin
      flash_done <= (done_cnt == 1);
      if (flash_start)
        done_cnt <= done_dly;
      else if (done_cnt != 0)
        done_cnt <= done_cnt - 1;
    end
  end
endmodule

// ### pkg/fuq_pkg.sv
/*
  Constants for the flash unlock sequencer and identification readout.
  Assumes a single 100 MHz core clock; register writes arrive as one-cycle strobes.
*/
package fuq_pkg;
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned ROW_OP_TIME_US = 2000;  // typical row erase / program time, 2 ms
  localparam int unsigned ROW_OP_CYCLES  = ROW_OP_TIME_US * CLK_MHZ;
  localparam logic [7:0]  KEY_FIRST      = 8'h55;
  localparam logic [7:0]  KEY_SECOND     = 8'hAA;
  // configuration-space word addresses
  localparam logic [15:0] CFG_USER_ID_LO = 16'h8000;
  localparam logic [15:0] CFG_USER_ID_HI = 16'h8003;
  localparam logic [15:0] CFG_REV_ADDR   = 16'h8005;
  localparam logic [15:0] CFG_DEV_ADDR   = 16'h8006;
  localparam logic [15:0] CFG_WORD1_ADDR = 16'h8007;
  localparam logic [15:0] CFG_WORD2_ADDR = 16'h8008;
  localparam logic [13:0] ID_INVALID     = 14'h3FFF;
  localparam logic [13:0] DEV_ID_DEFAULT = 14'h0A5C;  // arbitrary value
  localparam logic [13:0] REV_ID_DEFAULT = 14'h0101;  // arbitrary value
  localparam logic [13:0] CFG_WORD_RESET = 14'h3FFF;
  localparam logic [13:0] USER_ID_RESET  = 14'h0000;
  localparam int unsigned FORCED_NOPS    = 2;
  // operation codes carried with the write trigger
  localparam logic [1:0]  OP_LOAD_LATCH  = 2'h0;
  localparam logic [1:0]  OP_ROW_PROGRAM = 2'h1;
  localparam logic [1:0]  OP_ROW_ERASE   = 2'h2;
  localparam logic [1:0]  OP_USER_ID_WR  = 2'h3;
endpackage

// ### verilog/fuq_flash_seq.sv
/*
  Flash unlock sequencer with forced idle slots, core stall and config-space ID readout.
  Assumes the core issues one-cycle write strobes, an instruction-slot strobe, and a
  flash macro that reports completion; the row-time counter models the typical stall.
*/
// How it works
// - erase, load, program need full unlock first
// - two slots after trigger forced to no-op
// - row erase/program stalls core until done
// - latch load: two no-ops, no stall
// - read-only 14-bit part identity word
// - identity word never reads all ones
// - read-only 14-bit silicon revision word
// - user IDs writable; ID and config words read-only
// - unsupported config read clears data registers
module fuq_flash_seq
  import fuq_pkg::*;
#(
  parameter int unsigned ROW_CYCLES = ROW_OP_CYCLES
)
(
  input  wire logic        clk,           // core clock
  input  wire logic        resetn,        // async active-low reset
  input  wire logic        key_wr,        // write strobe, unlock key register
  input  wire logic [7:0]  key_data,      // key value
  input  wire logic        other_wr,      // any other register write
  input  wire logic        wr_trigger,    // write-initiate bit set
  input  wire logic [1:0]  wr_op,         // operation kind
  input  wire logic [1:0]  wr_uid_sel,    // user ID index
  input  wire logic [13:0] wr_word,       // data from latches
  input  wire logic        slot,          // one instruction slot elapses
  input  wire logic        flash_done,    // flash macro finished
  input  wire logic        rd_trigger,    // read-initiate bit set
  input  wire logic        config_space_select, // config space chosen
  input  wire logic [15:0] rd_addr,       // word address for the read
  output logic             force_nop,     // current slot executes as no-op
  output logic             core_stall,    // halt core execution
  output logic             flash_start,   // one-cycle start to flash macro
  output logic             latch_load,    // one-cycle latch load strobe
  output logic             op_refused,    // sticky: trigger without unlock
  output logic [5:0]       memory_data_high, // high data register
  output logic [7:0]       memory_data_low   // low data register
);
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_NOP   = 4'b0010,
    ST_STALL = 4'b0100,
    ST_RESUME= 4'b1000
  } fuq_state_e;

  fuq_state_e  state;
  logic        rst_a;
  logic        rst_n;
  logic        unlocked;
  logic [1:0]  nop_left;
  logic        row_op;
  logic        done_seen;
  logic [31:0] row_cnt;
  logic [13:0] user_id [4];
  logic [13:0] cfg_word1;
  logic [13:0] cfg_word2;

  function automatic logic is_row_op(input logic [1:0] op);
    is_row_op = (op == OP_ROW_ERASE) || (op == OP_ROW_PROGRAM) || (op == OP_USER_ID_WR);
  endfunction

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_a <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_a <= 1'b1;
      rst_n <= rst_a;
    end
  end

  fuq_key_tracker u_keys (
    .clk      (clk),
    .rst_n    (rst_n),
    .key_wr   (key_wr),
    .key_data (key_data),
    .other_wr (other_wr),
    .consume  (wr_trigger),
    .unlocked (unlocked)
  );

  // sequence state: forced slots, then optional stall
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state     <= ST_IDLE;
      nop_left  <= 2'h0;
      row_op    <= 1'b0;
      force_nop <= 1'b0;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
        begin
          if (wr_trigger)
          begin
            state     <= ST_NOP;
            nop_left  <= 2'(FORCED_NOPS);
            row_op    <= unlocked && is_row_op(wr_op);
            force_nop <= 1'b1;
          end
        end
        ST_NOP:
        begin
          if (slot)
          begin
            if (nop_left == 2'h1)
            begin
              force_nop <= 1'b0;
              state     <= row_op ? ST_STALL : ST_IDLE;
            end
            nop_left <= nop_left - 2'h1;
          end
        end
        ST_STALL:
        begin
          if (flash_done || done_seen || row_cnt == 32'h0)
          begin
            state <= ST_RESUME;
          end
        end
        ST_RESUME:
        begin
          state  <= ST_IDLE;
          row_op <= 1'b0;
        end
      endcase
    end
  end

  // a done landing inside the forced slots must not be lost, or the stall would run to timeout
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      done_seen <= 1'b0;
    else
      done_seen <= (state == ST_NOP) && (done_seen || flash_done);
  end

  // stall covers the flash busy time
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      core_stall <= 1'b0;
      row_cnt    <= 32'h0;
    end
    else if (state == ST_NOP && slot && nop_left == 2'h1 && row_op)
    begin
      core_stall <= 1'b1;
      row_cnt    <= 32'(ROW_CYCLES - 1);
    end
    else if (state == ST_STALL)
    begin
      if (flash_done || done_seen || row_cnt == 32'h0)
      begin
        core_stall <= 1'b0;
      end
      else
      begin
        row_cnt <= row_cnt - 32'h1;
      end
    end
  end

  // strobes only when unlocked: a refused trigger still burns its two slots
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flash_start <= 1'b0;
      latch_load  <= 1'b0;
      op_refused  <= 1'b0;
    end
    else
    begin
      flash_start <= 1'b0;
      latch_load  <= 1'b0;
      if (state == ST_IDLE && wr_trigger)
      begin
        if (unlocked)
        begin
          flash_start <= is_row_op(wr_op);
          latch_load  <= (wr_op == OP_LOAD_LATCH);
        end
        else
        begin
          op_refused <= 1'b1;
        end
      end
    end
  end

  // user ID words change only through an unlocked user-ID write
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      user_id[0] <= USER_ID_RESET;
      user_id[1] <= USER_ID_RESET;
      user_id[2] <= USER_ID_RESET;
      user_id[3] <= USER_ID_RESET;
      cfg_word1  <= CFG_WORD_RESET;
      cfg_word2  <= CFG_WORD_RESET;
    end
    else if (state == ST_IDLE && wr_trigger && unlocked && wr_op == OP_USER_ID_WR)
    begin
      user_id[wr_uid_sel] <= wr_word;
    end
  end

  // config-space read path; ID words are constants, never written
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      memory_data_high <= 6'h00;
      memory_data_low  <= 8'h00;
    end
    else if (rd_trigger && config_space_select)
    begin
      if (rd_addr >= CFG_USER_ID_LO && rd_addr <= CFG_USER_ID_HI)
      begin
        {memory_data_high, memory_data_low} <= user_id[rd_addr[1:0]];
      end
      else if (rd_addr == CFG_DEV_ADDR)
      begin
        {memory_data_high, memory_data_low} <= DEV_ID_DEFAULT;
      end
      else if (rd_addr == CFG_REV_ADDR)
      begin
        {memory_data_high, memory_data_low} <= REV_ID_DEFAULT;
      end
      else if (rd_addr == CFG_WORD1_ADDR)
      begin
        {memory_data_high, memory_data_low} <= cfg_word1;
      end
      else if (rd_addr == CFG_WORD2_ADDR)
      begin
        {memory_data_high, memory_data_low} <= cfg_word2;
      end
      else
      begin
        memory_data_high <= 6'h00;
        memory_data_low  <= 8'h00;
      end
    end
  end

  property p_two_nops;
    @(posedge clk) disable iff (!rst_n)
    (state == ST_IDLE && wr_trigger) |=> force_nop;
  endproperty
  a_two_nops: assert property (p_two_nops) else $error("trigger did not force no-op");

  property p_load_no_stall;
    @(posedge clk) disable iff (!rst_n)
    (state == ST_IDLE && wr_trigger && wr_op == OP_LOAD_LATCH) |=> !core_stall [*3];
  endproperty
  a_load_no_stall: assert property (p_load_no_stall) else $error("latch load stalled core");

  property p_locked_no_start;
    @(posedge clk) disable iff (!rst_n)
    (wr_trigger && !unlocked) |=> !flash_start && !latch_load;
  endproperty
  a_locked_no_start: assert property (p_locked_no_start) else $error("operation without unlock");

  property p_unlocked_start;
    @(posedge clk) disable iff (!rst_n)
    (state == ST_IDLE && wr_trigger && unlocked && wr_op == OP_ROW_ERASE) |=> flash_start;
  endproperty
  a_unlocked_start: assert property (p_unlocked_start) else $error("erase not started");

  property p_stall_ends;
    @(posedge clk) disable iff (!rst_n)
    (core_stall && flash_done) |=> !core_stall;
  endproperty
  a_stall_ends: assert property (p_stall_ends) else $error("stall held after done");

  property p_bad_read_zero;
    @(posedge clk) disable iff (!rst_n)
    (rd_trigger && config_space_select && rd_addr == 16'h8004) |=> {memory_data_high, memory_data_low} == 14'h0;
  endproperty
  a_bad_read_zero: assert property (p_bad_read_zero) else $error("bad read not cleared");

  property p_dev_read;
    @(posedge clk) disable iff (!rst_n)
    (rd_trigger && config_space_select && rd_addr == CFG_DEV_ADDR) |=>
      ({memory_data_high, memory_data_low} == DEV_ID_DEFAULT) && (DEV_ID_DEFAULT != ID_INVALID);
  endproperty
  a_dev_read: assert property (p_dev_read) else $error("identity read wrong");

  property p_rev_read;
    @(posedge clk) disable iff (!rst_n)
    (rd_trigger && config_space_select && rd_addr == CFG_REV_ADDR) |=>
      {memory_data_high, memory_data_low} == REV_ID_DEFAULT;
  endproperty
  a_rev_read: assert property (p_rev_read) else $error("revision read wrong");
endmodule

// ### verilog/fuq_key_tracker.sv
/*
  Tracks the two-key unlock sequence written to the unlock key register.
  Assumes any other register write in between breaks the sequence.
*/
module fuq_key_tracker
  import fuq_pkg::*;
(
  input  wire logic       clk,        // core clock
  input  wire logic       rst_n,      // synchronised reset
  input  wire logic       key_wr,     // write strobe to unlock key register
  input  wire logic [7:0] key_data,   // written value
  input  wire logic       other_wr,   // any other register write
  input  wire logic       consume,    // write-initiate taken, sequence used up
  output logic            unlocked    // both keys seen in order
);
  logic first_seen;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      first_seen <= 1'b0;
      unlocked   <= 1'b0;
    end
    else if (consume || other_wr)
    begin
      first_seen <= 1'b0;
      unlocked   <= 1'b0;
    end
    else if (key_wr)
    begin
      first_seen <= (key_data == KEY_FIRST);
      unlocked   <= first_seen && (key_data == KEY_SECOND);
    end
  end
endmodule
